// ==== kmw_defines.svh ====
// register offsets, field positions and reset values for the keyboard/mouse wake glue
`ifndef KMW_DEFINES_SVH
`define KMW_DEFINES_SVH

// byte addresses on the register bus
`define KMW_OFF_WAKE_STATUS 8'h00
`define KMW_OFF_WAKE_ENABLE 8'h04
`define KMW_OFF_WAKE_CTRL 8'h08
`define KMW_OFF_LINE_STATE 8'h0C
`define KMW_OFF_GLOBAL_CFG 8'h2C
`define KMW_OFF_KBD_GATE_CFG 8'hF0

// wake event bit positions, shared by status and enable
`define KMW_WK_KBD_IRQ 0
`define KMW_WK_MOUSE_IRQ 1
`define KMW_WK_KBD_DATA 2
`define KMW_WK_MOUSE_DATA 3
`define KMW_WK_W 4

// keyboard_gate_config fields
`define KMW_KGC_KBD_LATCH 3
`define KMW_KGC_MOUSE_LATCH 4
`define KMW_KGC_KBD_ISO 5
`define KMW_KGC_MOUSE_ISO 6

// global configuration: embedded controller reset bit
`define KMW_GCFG_CTL_RST 6

// wake control: global wake enable bit
`define KMW_CTRL_GLOBAL_EN 0

// reset values
`define KMW_RST_BYTE 8'h00
`define KMW_RST_WAKE 4'h0
`define KMW_RST_WORD 32'h0000_0000
`define KMW_LINE_IDLE 1'h1

`endif

// ==== kmw_pkg.sv ====
// state types for the keyboard/mouse wake glue
`include "kmw_defines.svh"

package kmw_pkg;

	// state of one interrupt latch
	typedef struct packed {
		logic raw_d; // raw interrupt one cycle ago
		logic latched; // captured rising interrupt
		logic out; // selected interrupt output
	} kmw_latch_state_t;

	// state of the main glue block
	typedef struct packed {
		logic ack; // bus access answered this cycle
		logic [31:0] rdata; // read data for the bus
		logic [`KMW_WK_W-1:0] status; // sticky wake status
		logic [`KMW_WK_W-1:0] enable; // per-event wake enable
		logic gen; // global wake enable
		logic [7:0] gcfg; // global configuration byte
		logic [7:0] kgc; // keyboard gate configuration byte
		logic kbd_data_line_prev; // keyboard data, last cycle
		logic mouse_data_line_prev; // mouse data, last cycle
		logic kirq_prev; // keyboard irq output, last cycle
		logic mirq_prev; // mouse irq output, last cycle
		logic kbd_clock_line_ctl; // keyboard clock into controller
		logic kbd_data_line_ctl; // keyboard data into controller
		logic mclk_ctl; // mouse clock into controller
		logic mouse_data_line_ctl; // mouse data into controller
		logic pme; // power management event
	} kmw_state_t;

endpackage

// ==== kmw_sync.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none

module kmw_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// asynchronous inputs
	input wire logic [W-1:0] async_i,
	// filtered synchronous outputs
	output logic [W-1:0] sync_o
);

	// whole synchroniser state
	typedef struct packed {
		logic [W-1:0] s1; // first stage, read only by s2
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val; // accepted value
	} kmw_sync_state_t;

	kmw_sync_state_t st_reg;
	kmw_sync_state_t st_next;

	// a bit changes only once stages two and three agree
	always_comb begin
		st_next = st_reg;
		st_next.s1 = async_i;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.val[i] = st_reg.s3[i];
			end
		end
	end

	// registers, constant reset only
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= {INIT, INIT, INIT, INIT};
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_o = st_reg.val;

endmodule // kmw_sync
`default_nettype wire

// ==== kmw_irq_latch.sv ====
// interrupt latch with selectable latched or combined output
`timescale 1ns/1ps
`default_nettype none

module kmw_irq_latch (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// raw interrupt from the embedded controller
	input wire logic raw_i,
	// select: 1 latched alone, 0 raw and latched
	input wire logic sel_i,
	// selected interrupt
	output logic out_o
);

	kmw_pkg::kmw_latch_state_t st_reg;
	kmw_pkg::kmw_latch_state_t st_next;

	// capture a rising raw irq, drop it once raw goes low
	always_comb begin
		st_next = st_reg;
		st_next.raw_d = raw_i;
		st_next.latched = raw_i & (st_reg.latched | ~st_reg.raw_d); // see R15
		if (sel_i) begin
			st_next.out = st_next.latched; // see R1 see R2
		end else begin
			st_next.out = raw_i & st_next.latched; // see R1 see R2
		end
	end

	// latch clears on system reset
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= '0; // see R15
		end else begin
			st_reg <= st_next;
		end
	end

	assign out_o = st_reg.out;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	a_latch_hold: assert property (st_reg.latched && raw_i |=> st_reg.latched) // see R15
		else $error("latch lost while raw irq still high");
	a_latch_drop: assert property (!raw_i |=> !st_reg.latched && !out_o) // see R15
		else $error("latch or output held after raw irq dropped");
	a_latch_sel: assert property ($rose(raw_i) |=> out_o == 1'h1) // see R1
		else $error("rising irq not passed to output");

endmodule // kmw_irq_latch
`default_nettype wire

// ==== kmw_glue.sv ====
// keyboard and mouse wake, latch and isolation glue with register slave
//
// Contract
// R1 - mouse irq: latched alone or raw-and-latched
// R2 - keyboard irq: latched alone or raw-and-latched
// R3 - control bits live in gate config 0xF0
// R4 - four separate sticky wake status bits
// R5 - wake needs own enable and global enable
// R6 - irq wakes need main power; data wakes not
// R7 - mouse isolation blocks mouse lines to controller
// R8 - mouse data always reaches wake detection
// R9 - keyboard isolation blocks keyboard lines to controller
// R10 - keyboard data always reaches wake detection
// R11 - software resets controller after deep sleep isolation
// R12 - 0x40 to 0x2C holds controller reset
// R13 - software sets only bit 6 there
// R14 - no controller reset needed after light sleep
// R15 - latches catch rising irq, clear on reset
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "kmw_defines.svh"

module kmw_glue (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// avalon-mm register slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// serial lines from the keyboard and mouse
	input wire logic kbd_clock_line_i,
	input wire logic kbd_data_line_i,
	input wire logic mouse_clock_line_i,
	input wire logic mouse_data_line_i,
	// main power good, asynchronous
	input wire logic main_power_i,
	// raw interrupts from the embedded controller
	input wire logic kbd_irq_raw_i,
	input wire logic mouse_irq_raw_i,
	// lines into the embedded controller
	output logic kbd_clock_ctl_o,
	output logic kbd_data_ctl_o,
	output logic mouse_clock_ctl_o,
	output logic mouse_data_ctl_o,
	// selected interrupts to the host
	output logic kbd_irq_o,
	output logic mouse_irq_o,
	// embedded controller reset, held while set
	output logic ctl_reset_o,
	// power management event, level
	output logic pme_o
);

	// synchronised pins: kbd_clock_line, kbd_data_line, mclk, mouse_data_line, power
	logic [4:0] pins_sync;
	logic kbd_clock_line_s; // keyboard clock, synchronised
	logic kbd_data_line_s; // keyboard data, synchronised
	logic mclk_s; // mouse clock, synchronised
	logic mouse_data_line_s; // mouse data, synchronised
	logic power_s; // main power present
	logic kbd_irq; // selected keyboard irq
	logic mouse_irq; // selected mouse irq

	kmw_pkg::kmw_state_t st_reg;
	kmw_pkg::kmw_state_t st_next;

	// lines idle high, power assumed absent until seen
	kmw_sync #(
		.W(5),
		.INIT(5'h0F)
	) u_sync (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.async_i({main_power_i, mouse_data_line_i, mouse_clock_line_i,
			kbd_data_line_i, kbd_clock_line_i}),
		.sync_o(pins_sync)
	);

	assign kbd_clock_line_s = pins_sync[0];
	assign kbd_data_line_s = pins_sync[1];
	assign mclk_s = pins_sync[2];
	assign mouse_data_line_s = pins_sync[3];
	assign power_s = pins_sync[4];

	// keyboard interrupt latch
	kmw_irq_latch u_kbd_latch (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.raw_i(kbd_irq_raw_i),
		.sel_i(st_reg.kgc[`KMW_KGC_KBD_LATCH]), // see R2 see R3
		.out_o(kbd_irq)
	);

	// mouse interrupt latch
	kmw_irq_latch u_mouse_latch (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.raw_i(mouse_irq_raw_i),
		.sel_i(st_reg.kgc[`KMW_KGC_MOUSE_LATCH]), // see R1 see R3
		.out_o(mouse_irq)
	);

	// bus qualifiers
	logic req; // a request is on the bus
	logic wr_go; // write takes effect this edge
	logic lane0; // low byte lane enabled
	logic [`KMW_WK_W-1:0] wake_ev; // wake events this cycle
	logic [`KMW_WK_W-1:0] wake_clr; // status bits cleared by software

	// next state: bus slave, wake status, isolation
	always_comb begin
		st_next = st_reg;
		req = avs_read_i | avs_write_i;
		lane0 = avs_byteenable_i[0];
		wr_go = avs_write_i & st_reg.ack;
		wake_ev = `KMW_RST_WAKE;
		wake_clr = `KMW_RST_WAKE;

		// one wait cycle: answer on the second cycle of each request
		st_next.ack = req & ~st_reg.ack;

		// read data captured in the waiting cycle, unmapped reads zero
		st_next.rdata = `KMW_RST_WORD;
		if (avs_read_i && !st_reg.ack) begin
			case (avs_address_i)
				`KMW_OFF_WAKE_STATUS: begin
					st_next.rdata[`KMW_WK_W-1:0] = st_reg.status;
				end
				`KMW_OFF_WAKE_ENABLE: begin
					st_next.rdata[`KMW_WK_W-1:0] = st_reg.enable;
				end
				`KMW_OFF_WAKE_CTRL: begin
					st_next.rdata[`KMW_CTRL_GLOBAL_EN] = st_reg.gen;
				end
				`KMW_OFF_LINE_STATE: begin
					// live view of lines, power and irqs
					st_next.rdata[7:0] = {1'h0, mouse_irq, kbd_irq, power_s,
						mouse_data_line_s, mclk_s, kbd_data_line_s, kbd_clock_line_s};
				end
				`KMW_OFF_GLOBAL_CFG: begin
					st_next.rdata[7:0] = st_reg.gcfg;
				end
				`KMW_OFF_KBD_GATE_CFG: begin
					st_next.rdata[7:0] = st_reg.kgc; // see R3
				end
				default: begin
					st_next.rdata = `KMW_RST_WORD;
				end
			endcase
		end

		// writes land at the edge where waitrequest is low
		if (wr_go && lane0) begin
			case (avs_address_i)
				`KMW_OFF_WAKE_STATUS: begin
					wake_clr = avs_writedata_i[`KMW_WK_W-1:0];
				end
				`KMW_OFF_WAKE_ENABLE: begin
					st_next.enable = avs_writedata_i[`KMW_WK_W-1:0];
				end
				`KMW_OFF_WAKE_CTRL: begin
					st_next.gen = avs_writedata_i[`KMW_CTRL_GLOBAL_EN];
				end
				`KMW_OFF_GLOBAL_CFG: begin
					// reset bit is not self-clearing; other bits just stored
					st_next.gcfg = avs_writedata_i[7:0]; // see R12 see R13
				end
				`KMW_OFF_KBD_GATE_CFG: begin
					st_next.kgc = avs_writedata_i[7:0]; // see R3
				end
				default: begin
					// unmapped or read-only: ignored
					st_next.gcfg = st_reg.gcfg;
				end
			endcase
		end

		// edge history for event detection
		st_next.kbd_data_line_prev = kbd_data_line_s;
		st_next.mouse_data_line_prev = mouse_data_line_s;
		st_next.kirq_prev = kbd_irq;
		st_next.mirq_prev = mouse_irq;

		// irq wakes only while main power is present
		wake_ev[`KMW_WK_KBD_IRQ] = power_s & kbd_irq & ~st_reg.kirq_prev; // see R4 see R6
		wake_ev[`KMW_WK_MOUSE_IRQ] = power_s & mouse_irq & ~st_reg.mirq_prev; // see R4 see R6
		// falling data edge is the start bit; taken before isolation
		wake_ev[`KMW_WK_KBD_DATA] = st_reg.kbd_data_line_prev & ~kbd_data_line_s; // see R4 see R10
		wake_ev[`KMW_WK_MOUSE_DATA] = st_reg.mouse_data_line_prev & ~mouse_data_line_s; // see R4 see R8

		// sticky status: a new event wins over a same-cycle clear
		st_next.status = (st_reg.status & ~wake_clr) | wake_ev; // see R4

		// pme needs the event's own enable and the global enable
		st_next.pme = st_reg.gen & (|(st_reg.status & st_reg.enable)); // see R5

		// isolated lines are held at the idle high level
		if (st_reg.kgc[`KMW_KGC_KBD_ISO]) begin
			st_next.kbd_clock_line_ctl = `KMW_LINE_IDLE; // see R9
			st_next.kbd_data_line_ctl = `KMW_LINE_IDLE; // see R9
		end else begin
			st_next.kbd_clock_line_ctl = kbd_clock_line_s; // see R9
			st_next.kbd_data_line_ctl = kbd_data_line_s; // see R9
		end
		if (st_reg.kgc[`KMW_KGC_MOUSE_ISO]) begin
			st_next.mclk_ctl = `KMW_LINE_IDLE; // see R7
			st_next.mouse_data_line_ctl = `KMW_LINE_IDLE; // see R7
		end else begin
			st_next.mclk_ctl = mclk_s; // see R7
			st_next.mouse_data_line_ctl = mouse_data_line_s; // see R7
		end
	end

	// one register bank; latch selects and isolation clear on reset
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
			st_reg.kgc <= `KMW_RST_BYTE; // see R15
			st_reg.kbd_data_line_prev <= `KMW_LINE_IDLE;
			st_reg.mouse_data_line_prev <= `KMW_LINE_IDLE;
			st_reg.kbd_clock_line_ctl <= `KMW_LINE_IDLE;
			st_reg.kbd_data_line_ctl <= `KMW_LINE_IDLE;
			st_reg.mclk_ctl <= `KMW_LINE_IDLE;
			st_reg.mouse_data_line_ctl <= `KMW_LINE_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs
	assign avs_waitrequest_o = req & ~st_reg.ack;
	assign avs_readdata_o = st_reg.rdata;
	assign kbd_clock_ctl_o = st_reg.kbd_clock_line_ctl;
	assign kbd_data_ctl_o = st_reg.kbd_data_line_ctl;
	assign mouse_clock_ctl_o = st_reg.mclk_ctl;
	assign mouse_data_ctl_o = st_reg.mouse_data_line_ctl;
	assign kbd_irq_o = kbd_irq;
	assign mouse_irq_o = mouse_irq;
	// held until software writes the bit back to zero
	assign ctl_reset_o = st_reg.gcfg[`KMW_GCFG_CTL_RST]; // see R11 see R12 see R14
	assign pme_o = st_reg.pme;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	a_bus_wait_one: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o) // bus timing, decided locally
		else $error("bus request not answered after one wait cycle");
	a_gate_cfg_write: assert property (wr_go && lane0 && avs_address_i == `KMW_OFF_KBD_GATE_CFG
		|=> st_reg.kgc == $past(avs_writedata_i[7:0])) // see R3
		else $error("gate config write not stored");
	a_pme_gating: assert property (pme_o == $past(st_reg.gen &
		(|(st_reg.status & st_reg.enable)))) // see R5
		else $error("pme not gated by both enables");
	a_kdata_wake: assert property (st_reg.kbd_data_line_prev && !kbd_data_line_s
		|=> st_reg.status[`KMW_WK_KBD_DATA]) // see R10
		else $error("keyboard data edge missed by wake logic");
	a_mdata_wake: assert property (st_reg.mouse_data_line_prev && !mouse_data_line_s
		|=> st_reg.status[`KMW_WK_MOUSE_DATA]) // see R8
		else $error("mouse data edge missed by wake logic");
	a_irq_power: assert property ($rose(st_reg.status[`KMW_WK_KBD_IRQ]) |-> $past(power_s)) // see R6
		else $error("keyboard irq wake without main power");
	a_kbd_iso: assert property (st_reg.kgc[`KMW_KGC_KBD_ISO]
		|=> kbd_clock_ctl_o && kbd_data_ctl_o) // see R9
		else $error("keyboard lines not blocked while isolated");
	a_mouse_iso: assert property (st_reg.kgc[`KMW_KGC_MOUSE_ISO]
		|=> mouse_clock_ctl_o && mouse_data_ctl_o) // see R7
		else $error("mouse lines not blocked while isolated");
	a_kbd_pass: assert property (!st_reg.kgc[`KMW_KGC_KBD_ISO]
		|=> kbd_data_ctl_o == $past(kbd_data_line_s)) // see R9
		else $error("keyboard data not passed when not isolated");
	a_ctl_reset_hold: assert property (ctl_reset_o &&
		!(wr_go && avs_address_i == `KMW_OFF_GLOBAL_CFG) |=> ctl_reset_o) // see R12
		else $error("controller reset released without a write");

	c_pme_rise: cover property ($rose(pme_o));
	c_iso_wake: cover property (st_reg.kgc[`KMW_KGC_KBD_ISO] &&
		wake_ev[`KMW_WK_KBD_DATA]);
	c_status_read: cover property (avs_read_i && !avs_waitrequest_o &&
		avs_address_i == `KMW_OFF_WAKE_STATUS);
	c_ctl_reset: cover property ($fell(ctl_reset_o));

endmodule // kmw_glue
`default_nettype wire

// ==== kmw_ps2_model.sv ====
// keyboard or mouse device model on one serial clock/data pair
`timescale 1ns/1ps
`default_nettype none

module kmw_ps2_model (
	// pacing clock
	input wire logic clock_i,
	// serial lines, pulled up when released
	output logic clk_line_o,
	output logic data_line_o
);
	// released lines sit at the pull-up level
	initial begin
		clk_line_o = 1'b1;
		data_line_o = 1'b1;
	end

	// one frame: start, data lsb first, odd parity, stop
	// link clock 160 ns, runs only inside the frame
	task automatic send_byte(input logic [7:0] b);
		logic [10:0] f;
		f = {1'b1, ~^b, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			// data moves mid-high; clock low 80 ns, high 80 ns
			data_line_o <= f[i]; // falling start bit is the wake cause
			repeat (4) @(posedge clock_i);
			clk_line_o <= 1'b0;
			repeat (8) @(posedge clock_i);
			clk_line_o <= 1'b1;
			repeat (4) @(posedge clock_i);
		end
	endtask
endmodule // kmw_ps2_model
`default_nettype wire

// ==== kmw_glue_tb_top.sv ====
// self-checking bench for the keyboard/mouse wake glue
`timescale 1ns/1ps
`default_nettype none
`include "kmw_defines.svh"

module kmw_glue_tb_top;
	logic clock_i, sys_rst_i, avs_read_i, avs_write_i, main_power_i;
	logic [7:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [3:0] avs_byteenable_i;
	logic avs_waitrequest_o, kcl, kdl, mcl, mdl, kbd_irq_raw_i, mouse_irq_raw_i;
	logic kbd_clock_ctl_o, kbd_data_ctl_o, mouse_clock_ctl_o, mouse_data_ctl_o;
	logic kbd_irq_o, mouse_irq_o, ctl_reset_o, pme_o;
	int failures, checks_done, cyc, k_low, m_low, kb, mb;

	kmw_glue DUT (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.kbd_clock_line_i(kcl), .kbd_data_line_i(kdl),
		.mouse_clock_line_i(mcl), .mouse_data_line_i(mdl),
		.main_power_i(main_power_i),
		.kbd_irq_raw_i(kbd_irq_raw_i), .mouse_irq_raw_i(mouse_irq_raw_i),
		.kbd_clock_ctl_o(kbd_clock_ctl_o), .kbd_data_ctl_o(kbd_data_ctl_o),
		.mouse_clock_ctl_o(mouse_clock_ctl_o), .mouse_data_ctl_o(mouse_data_ctl_o),
		.kbd_irq_o(kbd_irq_o), .mouse_irq_o(mouse_irq_o),
		.ctl_reset_o(ctl_reset_o), .pme_o(pme_o)
	);
	// external keyboard and mouse
	kmw_ps2_model kbd_dev (.clock_i(clock_i), .clk_line_o(kcl), .data_line_o(kdl));
	kmw_ps2_model mouse_dev (.clock_i(clock_i), .clk_line_o(mcl), .data_line_o(mdl));

	// 100 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// count lows reaching the controller; counters avoid clearing races
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (kbd_clock_ctl_o === 1'b0 || kbd_data_ctl_o === 1'b0) k_low <= k_low + 1;
		if (mouse_clock_ctl_o === 1'b0 || mouse_data_ctl_o === 1'b0) m_low <= m_low + 1;
		if (cyc == 20000) begin
			failures++; // hang guard
			test_done();
		end
	end

	// compare and count
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// avalon write, held until waitrequest sampled low
	task av_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= 1'b1;
		@(posedge clock_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
		avs_write_i <= 1'b0;
	endtask

	// avalon read, data taken at the completing edge
	task av_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		avs_address_i <= a;
		avs_read_i <= 1'b1;
		@(posedge clock_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
		d = avs_readdata_o;
		avs_read_i <= 1'b0;
	endtask

	// read, compare
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		av_read(a, rd);
		chk(nm, e, rd);
	endtask

	// bounded poll until masked bits match
	task poll(input string nm, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		do begin
			av_read(`KMW_OFF_WAKE_STATUS, rd);
			n++;
		end while ((rd & m) !== e && n < 40);
		chk(nm, e, rd & m);
	endtask

	// raw irq pulse held for three cycles, then low for three
	task irq_pulse(input logic k, input logic m);
		@(posedge clock_i);
		kbd_irq_raw_i <= k;
		mouse_irq_raw_i <= m;
		repeat (3) @(posedge clock_i);
		chk("irq_hi", {k, m}, {kbd_irq_o, mouse_irq_o});
		kbd_irq_raw_i <= 1'b0;
		mouse_irq_raw_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk("irq_lo", 2'h0, {kbd_irq_o, mouse_irq_o});
	endtask

	// verdict and end of run
	task test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// main sequence
	initial begin
		failures = 0; checks_done = 0; cyc = 0; k_low = 0; m_low = 0;
		sys_rst_i = 1'b1; avs_read_i = 1'b0; avs_write_i = 1'b0;
		avs_address_i = 8'h00; avs_writedata_i = 32'h0; avs_byteenable_i = 4'hF;
		main_power_i = 1'b1; kbd_irq_raw_i = 1'b0; mouse_irq_raw_i = 1'b0;
		repeat (8) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		// reset state, unmapped place
		chk("outs", 8'h0F, {ctl_reset_o, pme_o, kbd_irq_o, mouse_irq_o, kbd_clock_ctl_o,
			kbd_data_ctl_o, mouse_clock_ctl_o, mouse_data_ctl_o});
		rchk("gate", `KMW_OFF_KBD_GATE_CFG, 32'h0);
		rchk("gcfg", `KMW_OFF_GLOBAL_CFG, 32'h0);
		av_write(8'h40, 32'hFF);
		rchk("unmapped", 8'h40, 32'h0);
		// low byte lane off: write must be ignored
		avs_byteenable_i <= 4'hE;
		av_write(`KMW_OFF_KBD_GATE_CFG, 32'hFF);
		avs_byteenable_i <= 4'hF;
		rchk("be_off", `KMW_OFF_KBD_GATE_CFG, 32'h0);
		$display("test reset done");
		// every latch select combination
		for (int s = 0; s < 4; s++) begin
			av_write(`KMW_OFF_KBD_GATE_CFG, 32'(s) << 3);
			rchk("gate_rb", `KMW_OFF_KBD_GATE_CFG, 32'(s) << 3);
			irq_pulse(1'b1, 1'b1);
		end
		$display("test latch done");
		// irq wakes: enable, mask, global, clear
		av_write(`KMW_OFF_WAKE_STATUS, 32'hF);
		av_write(`KMW_OFF_WAKE_ENABLE, 32'h3);
		av_write(`KMW_OFF_WAKE_CTRL, 32'h1);
		chk("pme_idle", 1'b0, pme_o);
		irq_pulse(1'b1, 1'b0);
		poll("kirq_wake", 32'hF, 32'h1);
		chk("pme_on", 1'b1, pme_o);
		av_write(`KMW_OFF_WAKE_ENABLE, 32'h2);
		repeat (3) @(posedge clock_i);
		chk("pme_mask", 1'b0, pme_o);
		av_write(`KMW_OFF_WAKE_ENABLE, 32'h3);
		av_write(`KMW_OFF_WAKE_CTRL, 32'h0);
		repeat (3) @(posedge clock_i);
		chk("pme_gen", 1'b0, pme_o);
		av_write(`KMW_OFF_WAKE_CTRL, 32'h1);
		av_write(`KMW_OFF_WAKE_STATUS, 32'h1);
		irq_pulse(1'b0, 1'b1);
		poll("mirq_wake", 32'hF, 32'h2);
		chk("pme_m", 1'b1, pme_o);
		av_write(`KMW_OFF_WAKE_STATUS, 32'h2);
		rchk("w1c", `KMW_OFF_WAKE_STATUS, 32'h0);
		chk("pme_clr", 1'b0, pme_o);
		// deep sleep: no irq wakes on standby supply alone
		main_power_i <= 1'b0;
		repeat (8) @(posedge clock_i);
		irq_pulse(1'b1, 1'b1);
		repeat (8) @(posedge clock_i);
		rchk("nopower", `KMW_OFF_WAKE_STATUS, 32'h0);
		rchk("lines_off", `KMW_OFF_LINE_STATE, 32'h0F);
		$display("test irq_wake done");
		// isolated lines, data wakes still reach the wake logic
		av_write(`KMW_OFF_KBD_GATE_CFG, 32'h60);
		av_write(`KMW_OFF_WAKE_ENABLE, 32'hC);
		kb = k_low; mb = m_low;
		kbd_dev.send_byte(8'hA5);
		poll("kbd_data_line_wake", 32'hF, 32'h4);
		mouse_dev.send_byte(8'h3C);
		poll("mouse_data_line_wake", 32'hF, 32'hC);
		chk("iso_k", 1'b0, k_low != kb);
		chk("iso_m", 1'b0, m_low != mb);
		chk("pme_dat", 1'b1, pme_o);
		// leaving deep sleep with isolation used: pulse controller reset
		main_power_i <= 1'b1;
		av_write(`KMW_OFF_GLOBAL_CFG, 32'h40); // only bit 6
		@(posedge clock_i);
		chk("ctl_rst", 1'b1, ctl_reset_o);
		rchk("gcfg_rb", `KMW_OFF_GLOBAL_CFG, 32'h40);
		repeat (4) @(posedge clock_i);
		chk("ctl_hold", 1'b1, ctl_reset_o);
		av_write(`KMW_OFF_GLOBAL_CFG, 32'h0);
		@(posedge clock_i);
		chk("ctl_rel", 1'b0, ctl_reset_o);
		$display("test isolate done");
		// lines pass when not isolated
		av_write(`KMW_OFF_KBD_GATE_CFG, 32'h0);
		av_write(`KMW_OFF_WAKE_STATUS, 32'hF);
		kb = k_low; mb = m_low;
		kbd_dev.send_byte(8'h0F);
		mouse_dev.send_byte(8'hF0);
		poll("dat_wake", 32'hC, 32'hC);
		chk("pass_k", 1'b1, k_low != kb);
		chk("pass_m", 1'b1, m_low != mb);
		rchk("lines_on", `KMW_OFF_LINE_STATE, 32'h1F);
		$display("test pass done");
		test_done();
	end
endmodule // kmw_glue_tb_top
`default_nettype wire
